// ---- verilog/mctc_pkg.sv ----
// Shared constants, modes and configuration records of the match/capture timer
package mctc_pkg;

   // Structure sizes
   localparam int unsigned MCTC_W         = 32;
   localparam int unsigned MCTC_NCH       = 4;
   localparam int unsigned MCTC_NDMA      = 2;
   localparam int unsigned MCTC_NPWM      = 3;
   localparam int unsigned MCTC_SELW      = 2;

   // Reset and step values
   localparam logic [31:0] MCTC_CNT_RST   = 32'h0000_0000;
   localparam logic [31:0] MCTC_ONE       = 32'h0000_0001;
   localparam logic [3:0]  MCTC_FLAG_RST  = 4'h0;
   localparam logic [3:0]  MCTC_OUT_RST   = 4'h0;
   localparam logic [1:0]  MCTC_DMA_RST   = 2'h0;

   // Count source: internal clock or an edge of the external count input
   typedef enum logic [1:0] {
      MCTC_SRC_TIMER,
      MCTC_SRC_RISE,
      MCTC_SRC_FALL,
      MCTC_SRC_BOTH
   } mctc_src_t;

   // Action taken on a match output when its match occurs
   typedef enum logic [1:0] {
      MCTC_ACT_NONE,
      MCTC_ACT_LOW,
      MCTC_ACT_HIGH,
      MCTC_ACT_TOGGLE
   } mctc_act_t;

   // Per match channel configuration
   typedef struct packed {
      logic      int_en;
      logic      rst_en;
      logic      stop_en;
      logic      pwm_en;
      logic      shadow_en;
      mctc_act_t act;
   } mctc_mcfg_t;

   // Per capture channel configuration
   typedef struct packed {
      logic rise;
      logic fall;
      logic int_en;
   } mctc_ccfg_t;

   // Clear of counter and prescaler on a chosen capture event
   typedef struct packed {
      logic                 en;
      logic [MCTC_SELW-1:0] sel;
   } mctc_clr_t;

endpackage : mctc_pkg

// ---- verilog/mctc_edge.sv ----
// Edge detector for a synchronous input with selectable edges
module mctc_edge (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic resetn,
   // Watched signal and edge selection
   input  wire logic sig,
   input  wire logic rise_en,
   input  wire logic fall_en,
   // One-cycle event
   output logic      ev
);

   logic last;
   logic next_last;

   // Previous sample
   always_comb begin
      next_last = sig;
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         last <= 1'b0;
      end else begin
         last <= next_last;
      end
   end

   // Selected transitions
   assign ev = (rise_en && sig && !last) || (fall_en && !sig && last);

endmodule : mctc_edge

// ---- verilog/mctc_match_reg.sv ----
// Match value holder with optional shadow reload
module mctc_match_reg (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // Programmed value and reload control
   input  wire logic        shadow_en,
   input  wire logic        load,
   input  wire logic [31:0] wr_val,
   // Value in use by the comparator
   output logic [31:0]      active
);

   logic [31:0] next_active;

   // Follow directly, or only on load (period boundary or counter stopped) when shadowed
   always_comb begin
      next_active = active;
      if (!shadow_en || load) begin
         next_active = wr_val;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         active <= mctc_pkg::MCTC_CNT_RST;
      end else begin
         active <= next_active;
      end
   end

   property p_shadow_hold;
      @(posedge core_clk) disable iff (!resetn)
      shadow_en && !load |=> active == $past(active);
   endproperty
   a_shadow_hold: assert property (p_shadow_hold) else $error("shadowed value changed");

   property p_shadow_load;
      @(posedge core_clk) disable iff (!resetn)
      shadow_en && load |=> active == $past(wr_val);
   endproperty
   a_shadow_load: assert property (p_shadow_load) else $error("shadow not loaded");

endmodule : mctc_match_reg

// ---- verilog/mctc_timer.sv ----
// Match/capture timer-counter with prescaler, PWM and DMA requests
//
// Notes on behaviour
// - 32-bit counter advances through a 32-bit programmable prescaler.
// - Timer mode counts core clocks; counter mode counts external input edges.
// - A capture input transition copies the count into its capture register.
// - Capture events can raise an interrupt when enabled per channel.
// - Four match comparisons; continuous mode keeps counting, optional interrupt.
// - Stop-on-match halts the counter, optional interrupt.
// - Reset-on-match returns the counter to zero, optional interrupt.
// - PWM match values pass through shadow registers, reloaded at period start.
// - Match outputs go low, high, toggle or hold on their match.
// - Matches 0 and 1 can issue timed DMA requests.
// - A chosen capture event clears counter and prescaler.
// - Channels 0 to 2 give single-edge PWM, channel 3 sets the period.
module mctc_timer (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    resetn,
   // Run control
   input  wire logic                    run,
   input  wire logic                    start,
   input  wire logic                    sw_clear,
   // Count source
   input  wire mctc_pkg::mctc_src_t     src_mode,
   input  wire logic                    count_in,
   input  wire logic [31:0]             prescale,
   // Match channels
   input  wire logic [3:0][31:0]        match_val,
   input  wire mctc_pkg::mctc_mcfg_t [3:0] match_cfg,
   input  wire logic [3:0]              match_clr,
   input  wire logic [1:0]              dma_en,
   // Capture channels
   input  wire logic [3:0]              cap_in,
   input  wire mctc_pkg::mctc_ccfg_t [3:0] cap_cfg,
   input  wire logic [3:0]              cap_clr,
   input  wire mctc_pkg::mctc_clr_t     clr_cfg,
   // Counter state
   output logic [31:0]                  count,
   output logic [31:0]                  pre_count,
   output logic                         halted,
   // Capture results
   output logic [3:0][31:0]             cap_val,
   output logic [3:0]                   cap_flag,
   // Match results
   output logic [3:0]                   match_flag,
   output logic [3:0]                   match_out,
   output logic [1:0]                   dma_req,
   output logic                         irq
);

   ////////////////////////////////////////////////////////////////////////////
   // Event sources

   logic             src_edge;
   logic             src_ev;
   logic [3:0]       cap_ev;
   logic [3:0][31:0] mval;
   logic             load;

   // External count edges
   mctc_edge u_src_edge (
      .core_clk (core_clk),
      .resetn   (resetn),
      .sig      (count_in),
      .rise_en  (src_mode == mctc_pkg::MCTC_SRC_RISE || src_mode == mctc_pkg::MCTC_SRC_BOTH),
      .fall_en  (src_mode == mctc_pkg::MCTC_SRC_FALL || src_mode == mctc_pkg::MCTC_SRC_BOTH),
      .ev       (src_edge)
   );

   // Timer mode steps every clock, counter mode on input edges
   assign src_ev = (src_mode == mctc_pkg::MCTC_SRC_TIMER) ? 1'b1 : src_edge;

   // Per channel capture detectors and match holders
   for (genvar g = 0; g < mctc_pkg::MCTC_NCH; g++) begin : g_ch
      mctc_edge u_cap_edge (
         .core_clk (core_clk),
         .resetn   (resetn),
         .sig      (cap_in[g]),
         .rise_en  (cap_cfg[g].rise),
         .fall_en  (cap_cfg[g].fall),
         .ev       (cap_ev[g])
      );
      mctc_match_reg u_match (
         .core_clk  (core_clk),
         .resetn    (resetn),
         .shadow_en (match_cfg[g].shadow_en),
         .load      (load),
         .wr_val    (match_val[g]),
         .active    (mval[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Step and match decode

   logic        clr_any;
   logic        tick;
   logic        inc;
   logic        wrap;
   logic [31:0] after_inc;
   logic [3:0]  rst_hit;
   logic [3:0]  hit;
   logic        stop_hit;

   assign clr_any = sw_clear || (clr_cfg.en && cap_ev[clr_cfg.sel]);
   assign tick    = run && !halted && src_ev && !clr_any;
   assign inc     = tick && (pre_count == prescale);

   // Reset-on-match acts on the step after the count sits on the match
   always_comb begin
      rst_hit = 4'h0;
      for (int i = 0; i < mctc_pkg::MCTC_NCH; i++) begin
         rst_hit[i] = match_cfg[i].rst_en && (count == mval[i]);
      end
   end

   assign wrap      = inc && (|rst_hit);
   assign after_inc = wrap ? mctc_pkg::MCTC_CNT_RST : count + mctc_pkg::MCTC_ONE;
   assign load      = wrap || !run || halted;

   // Comparison on the value produced by each step
   always_comb begin
      hit      = 4'h0;
      stop_hit = 1'b0;
      for (int i = 0; i < mctc_pkg::MCTC_NCH; i++) begin
         hit[i]   = inc && (after_inc == mval[i]);
         stop_hit = stop_hit || (hit[i] && match_cfg[i].stop_en);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter and prescaler

   logic [31:0] next_count;
   logic [31:0] next_pre_count;
   logic        next_halted;

   // Clear has priority over stepping
   always_comb begin
      next_count     = count;
      next_pre_count = pre_count;
      next_halted    = halted;
      if (clr_any) begin
         next_count     = mctc_pkg::MCTC_CNT_RST;
         next_pre_count = mctc_pkg::MCTC_CNT_RST;
      end else if (inc) begin
         next_count     = after_inc;
         next_pre_count = mctc_pkg::MCTC_CNT_RST;
      end else if (tick) begin
         next_pre_count = pre_count + mctc_pkg::MCTC_ONE;
      end
      if (stop_hit) begin
         next_halted = 1'b1;
      end else if (start) begin
         next_halted = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         count     <= mctc_pkg::MCTC_CNT_RST;
         pre_count <= mctc_pkg::MCTC_CNT_RST;
         halted    <= 1'b0;
      end else begin
         count     <= next_count;
         pre_count <= next_pre_count;
         halted    <= next_halted;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Captures, flags and interrupt

   logic [3:0][31:0] next_cap_val;
   logic [3:0]       next_cap_flag;
   logic [3:0]       next_match_flag;
   logic             next_irq;

   // Sticky flags: a new event beats a clear in the same cycle
   always_comb begin
      next_cap_val    = cap_val;
      next_cap_flag   = (cap_flag & ~cap_clr) | cap_ev;
      next_match_flag = (match_flag & ~match_clr) | hit;
      next_irq        = 1'b0;
      for (int i = 0; i < mctc_pkg::MCTC_NCH; i++) begin
         if (cap_ev[i]) begin
            next_cap_val[i] = count;
         end
         if ((cap_flag[i] && cap_cfg[i].int_en) || (match_flag[i] && match_cfg[i].int_en)) begin
            next_irq = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cap_val    <= '0;
         cap_flag   <= mctc_pkg::MCTC_FLAG_RST;
         match_flag <= mctc_pkg::MCTC_FLAG_RST;
         irq        <= 1'b0;
      end else begin
         cap_val    <= next_cap_val;
         cap_flag   <= next_cap_flag;
         match_flag <= next_match_flag;
         irq        <= next_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Match outputs and DMA requests

   logic [3:0] next_match_out;
   logic [1:0] next_dma_req;

   // PWM channels drop at period start and rise on their match
   always_comb begin
      next_match_out = match_out;
      next_dma_req   = mctc_pkg::MCTC_DMA_RST;
      for (int i = 0; i < mctc_pkg::MCTC_NCH; i++) begin
         if (match_cfg[i].pwm_en && i < mctc_pkg::MCTC_NPWM) begin
            if (wrap) begin
               next_match_out[i] = 1'b0;
            end
            if (hit[i]) begin
               next_match_out[i] = 1'b1;
            end
         end else if (hit[i]) begin
            case (match_cfg[i].act)
               mctc_pkg::MCTC_ACT_LOW:    next_match_out[i] = 1'b0;
               mctc_pkg::MCTC_ACT_HIGH:   next_match_out[i] = 1'b1;
               mctc_pkg::MCTC_ACT_TOGGLE: next_match_out[i] = !match_out[i];
               default:                   next_match_out[i] = match_out[i];
            endcase
         end
      end
      for (int i = 0; i < mctc_pkg::MCTC_NDMA; i++) begin
         next_dma_req[i] = hit[i] && dma_en[i];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         match_out <= mctc_pkg::MCTC_OUT_RST;
         dma_req   <= mctc_pkg::MCTC_DMA_RST;
      end else begin
         match_out <= next_match_out;
         dma_req   <= next_dma_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   property p_pre_run;
      tick && !inc |=> pre_count == $past(pre_count) + 32'h0000_0001 && count == $past(count);
   endproperty
   a_pre_run: assert property (p_pre_run) else $error("prescaler did not step");

   property p_pre_wrap;
      inc |=> pre_count == 32'h0000_0000 && count == $past(after_inc);
   endproperty
   a_pre_wrap: assert property (p_pre_wrap) else $error("prescaler wrap wrong");

   property p_ctr_idle;
      src_mode != mctc_pkg::MCTC_SRC_TIMER && !src_edge && !clr_any
      |=> $stable(count) && $stable(pre_count);
   endproperty
   a_ctr_idle: assert property (p_ctr_idle) else $error("count moved without edge");

   property p_capture;
      cap_ev[1] |=> cap_val[1] == $past(count) && cap_flag[1];
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed");

   property p_cap_irq;
      cap_ev[1] && cap_cfg[1].int_en ##1 cap_cfg[1].int_en |=> irq;
   endproperty
   a_cap_irq: assert property (p_cap_irq) else $error("capture irq missing");

   property p_continue;
      hit[2] && !stop_hit |=> !halted;
   endproperty
   a_continue: assert property (p_continue) else $error("halted without stop");

   property p_stop;
      stop_hit |=> halted ##1 (halted || $past(start)) && $stable(count);
   endproperty
   a_stop: assert property (p_stop) else $error("stop on match failed");

   property p_reset;
      inc && rst_hit[1] |=> count == 32'h0000_0000;
   endproperty
   a_reset: assert property (p_reset) else $error("reset on match failed");

   property p_ext_high;
      hit[0] && !match_cfg[0].pwm_en && match_cfg[0].act == mctc_pkg::MCTC_ACT_HIGH
      |=> match_out[0];
   endproperty
   a_ext_high: assert property (p_ext_high) else $error("match output not high");

   property p_dma;
      hit[0] && dma_en[0] |=> dma_req[0] ##1 !dma_req[0] || $past(hit[0]);
   endproperty
   a_dma: assert property (p_dma) else $error("dma request wrong");

   property p_clear;
      clr_any |=> count == 32'h0000_0000 && pre_count == 32'h0000_0000;
   endproperty
   a_clear: assert property (p_clear) else $error("capture clear failed");

   property p_pwm_low;
      wrap && match_cfg[0].pwm_en && !hit[0] |=> !match_out[0];
   endproperty
   a_pwm_low: assert property (p_pwm_low) else $error("pwm not low at period");

   property p_mflag;
      hit[3] |=> match_flag[3];
   endproperty
   a_mflag: assert property (p_mflag) else $error("match flag not set");

   c_wrap:   cover property (wrap ##[1:20] hit[0]);
   c_stop:   cover property (stop_hit ##1 halted);
   c_clear:  cover property (clr_any && clr_cfg.en ##[1:20] cap_ev[1]);
   c_pwm:    cover property (match_cfg[0].pwm_en && hit[0] ##[1:40] wrap);

endmodule : mctc_timer

// ---- verif/mctc_pins.sv ----
// Far-side pin model: external count input and capture inputs
module mctc_pins (
   // Clock
   input  wire logic core_clk,
   // Pins toward the timer
   output logic       count_in,
   output logic [3:0] cap_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pins idle low until a pulse is asked for
   initial begin
      count_in = 1'h0;
      cap_in   = 4'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Count input pulses, gap sets how slowly the board answers
   task automatic ext_pulses(input int n, input int gap);
      repeat (n) begin
         @(posedge core_clk);
         count_in <= 1'h1;
         repeat (gap) @(posedge core_clk);
         count_in <= 1'h0;
         repeat (gap) @(posedge core_clk);
      end
   endtask : ext_pulses

   // One high pulse on the masked capture pins
   task automatic cap_pulse(input logic [3:0] mask, input int width);
      @(posedge core_clk);
      cap_in <= cap_in | mask;
      repeat (width) @(posedge core_clk);
      cap_in <= cap_in & ~mask;
   endtask : cap_pulse

endmodule : mctc_pins

// ---- verif/tb_top.sv ----
// Self-checking bench for the match/capture timer-counter
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic                       core_clk, resetn, run, start, sw_clear, count_in, halted, irq;
   mctc_pkg::mctc_src_t        src_mode;
   logic [31:0]                prescale, count, pre_count;
   logic [3:0][31:0]           match_val, cap_val;
   mctc_pkg::mctc_mcfg_t [3:0] match_cfg;
   mctc_pkg::mctc_ccfg_t [3:0] cap_cfg;
   mctc_pkg::mctc_clr_t        clr_cfg;
   logic [3:0]                 match_clr, cap_in, cap_clr, cap_flag, match_flag, match_out;
   logic [1:0]                 dma_en, dma_req;
   int                         bad_count, num_checks;

   ////////////////////////////////////////////////////////////////////////////////
   // Design and pin model
   mctc_timer dut_u (.core_clk(core_clk), .resetn(resetn), .run(run), .start(start),
      .sw_clear(sw_clear), .src_mode(src_mode), .count_in(count_in), .prescale(prescale),
      .match_val(match_val), .match_cfg(match_cfg), .match_clr(match_clr), .dma_en(dma_en),
      .cap_in(cap_in), .cap_cfg(cap_cfg), .cap_clr(cap_clr), .clr_cfg(clr_cfg), .count(count),
      .pre_count(pre_count), .halted(halted), .cap_val(cap_val), .cap_flag(cap_flag),
      .match_flag(match_flag), .match_out(match_out), .dma_req(dma_req), .irq(irq));
   mctc_pins pins_u (.core_clk(core_clk), .count_in(count_in), .cap_in(cap_in));

   ////////////////////////////////////////////////////////////////////////////////
   // Closing report
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: %s got %0h want %0h", $time, what, got, exp);
      end
   endtask : chk

   // Quiet configuration, clr raises all clears
   task automatic defaults(input logic clr);
      run       <= 1'h0;
      start     <= clr;
      sw_clear  <= clr;
      src_mode  <= mctc_pkg::MCTC_SRC_TIMER;
      prescale  <= 32'h0;
      match_val <= {4{32'hFFFF_FFFF}};
      match_cfg <= '0;
      match_clr <= {4{clr}};
      dma_en    <= 2'h0;
      cap_cfg   <= '0;
      cap_clr   <= {4{clr}};
      clr_cfg   <= '0;
   endtask : defaults

   // Clear count, flags and halt, then leave quiet
   task automatic setup();
      @(posedge core_clk);
      defaults(1'h1);
      @(posedge core_clk);
      defaults(1'h0);
      @(posedge core_clk);
   endtask : setup

   // Exactly n counting edges, then stop
   task automatic run_ticks(input int n);
      run <= 1'h1;
      repeat (n) @(posedge core_clk);
      run <= 1'h0;
      @(posedge core_clk);
      #1;
   endtask : run_ticks

   // Bounded wait for halt or for a count value
   task automatic wait_for(input logic on_halt, input logic [31:0] v);
      repeat (60) begin
         @(posedge core_clk);
         #1;
         if (on_halt ? halted === 1'h1 : count === v) begin
            return;
         end
      end
      bad_count++;
      $display("MISMATCH at %0t: wait ran out", $time);
      end_of_test();
   endtask : wait_for

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler steps, small and largest limit
   task automatic t_prescale();
      setup();
      prescale <= 32'h2;
      run_ticks(11);
      chk(count, 32'h3, "count");
      chk(pre_count, 32'h2, "pre");
      @(posedge core_clk);
      prescale <= 32'hFFFF_FFFF;
      run_ticks(5);
      chk(count, 32'h3, "count held");
      chk(pre_count, 32'h7, "pre wide");
      $display("prescale test done");
   endtask : t_prescale

   // External count input in each edge mode
   task automatic t_ext();
      for (int k = 1; k < 4; k++) begin
         setup();
         src_mode <= mctc_pkg::mctc_src_t'(k);
         run      <= 1'h1;
         pins_u.ext_pulses(5, k);
         @(posedge core_clk);
         run <= 1'h0;
         @(posedge core_clk);
         #1;
         chk(count, (k == 3) ? 32'hA : 32'h5, "ext count");
      end
      $display("external count test done");
   endtask : t_ext

   // Stop, continuous matches and output actions
   task automatic t_stop();
      logic [3:0] b;
      setup();
      b = match_out;
      match_val[0]         <= 32'h6;
      match_cfg[0].stop_en <= 1'h1;
      match_cfg[0].int_en  <= 1'h1;
      match_cfg[0].act     <= mctc_pkg::MCTC_ACT_HIGH;
      match_val[1]         <= 32'h3;
      match_cfg[1].act     <= mctc_pkg::MCTC_ACT_TOGGLE;
      match_val[3]         <= 32'h4;
      dma_en               <= 2'h1;
      run                  <= 1'h1;
      wait_for(1'h1, 32'h0);
      repeat (3) @(posedge core_clk);
      #1;
      chk(count, 32'h6, "stop count");
      chk(32'(match_out), 32'({b[3], b[2], ~b[1], 1'h1}), "outputs");
      chk(32'(match_flag), 32'hB, "flags");
      chk(32'(irq), 32'h1, "irq");
      @(posedge core_clk);
      match_clr <= 4'hF;
      @(posedge core_clk);
      match_clr <= 4'h0;
      repeat (2) @(posedge core_clk);
      #1;
      chk(32'({match_flag, irq}), 32'h0, "flag clear");
      @(posedge core_clk);
      match_val[0]     <= 32'h9;
      match_cfg[0].act <= mctc_pkg::MCTC_ACT_LOW;
      start            <= 1'h1;
      @(posedge core_clk);
      start <= 1'h0;
      wait_for(1'h1, 32'h0);
      chk(count, 32'h9, "restart");
      chk(32'(match_out[0]), 32'h0, "low");
      $display("stop test done");
   endtask : t_stop

   // Reset on match, toggle and timed DMA requests
   task automatic t_reset();
      logic        b;
      logic [31:0] top;
      int          n;
      setup();
      b   = match_out[1];
      top = 32'h0;
      n   = 0;
      match_val[1]        <= 32'h4;
      match_cfg[1].rst_en <= 1'h1;
      match_cfg[1].act    <= mctc_pkg::MCTC_ACT_TOGGLE;
      match_val[0]        <= 32'h2;
      match_val[2]        <= 32'h3;
      dma_en              <= 2'h2;
      run                 <= 1'h1;
      repeat (20) begin
         @(posedge core_clk);
         #1;
         n   += (dma_req[1] === 1'h1) ? 1 : 0;
         n   += (dma_req[0] !== 1'h0) ? 100 : 0;
         top  = (count > top) ? count : top;
      end
      @(posedge core_clk);
      run <= 1'h0;
      @(posedge core_clk);
      #1;
      chk(count, 32'h1, "wrap count");
      chk(top, 32'h4, "peak");
      chk(32'(n), 32'h4, "dma pulses");
      chk(32'(match_out[1]), 32'(b), "toggle");
      $display("reset test done");
   endtask : t_reset

   // Pulse width by clear on leading edge, capture on trailing edge
   task automatic t_cap();
      setup();
      cap_cfg[0].rise   <= 1'h1;
      cap_cfg[1].fall   <= 1'h1;
      cap_cfg[1].int_en <= 1'h1;
      clr_cfg.en        <= 1'h1;
      run               <= 1'h1;
      repeat (4) @(posedge core_clk);
      pins_u.cap_pulse(4'h3, 6);
      repeat (3) @(posedge core_clk);
      #1;
      chk(cap_val[0], 32'h5, "lead capture");
      chk(cap_val[1], 32'h5, "width");
      chk(32'({cap_flag, irq}), 32'h7, "cap flags");
      $display("capture test done");
   endtask : t_cap

   // Single-edge PWM with shadowed duty change
   task automatic t_pwm();
      int h;
      setup();
      match_val[3]           <= 32'h9;
      match_cfg[3].rst_en    <= 1'h1;
      match_val[0]           <= 32'h3;
      match_cfg[0].pwm_en    <= 1'h1;
      match_cfg[0].shadow_en <= 1'h1;
      @(posedge core_clk);
      run <= 1'h1;
      for (int p = 0; p < 2; p++) begin
         repeat (12) @(posedge core_clk);
         h = 0;
         repeat (10) begin
            @(posedge core_clk);
            #1;
            h += (match_out[0] === 1'h1) ? 1 : 0;
         end
         chk(32'(h), (p == 1) ? 32'h4 : 32'h7, "duty");
         if (p == 0) begin
            wait_for(1'h0, 32'h0);
            @(posedge core_clk);
            match_val[0] <= 32'h6;
            wait_for(1'h0, 32'h4);
            chk(32'(match_out[0]), 32'h1, "shadow");
         end
      end
      $display("pwm test done");
   endtask : t_pwm

   ////////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Reset, then every scenario in turn
   initial begin
      bad_count  = 0;
      num_checks = 0;
      resetn    <= 1'h0;
      defaults(1'h0);
      repeat (8) @(posedge core_clk);
      resetn <= 1'h1;
      t_prescale();
      t_ext();
      t_stop();
      t_reset();
      t_cap();
      t_pwm();
      end_of_test();
   end

endmodule : tb_top
